// *** src/flash_dma_consts.svh ***
`ifndef FLASH_DMA_CONSTS_SVH
`define FLASH_DMA_CONSTS_SVH

// Register byte offsets on the AHB-Lite port.
`define FD_REG_CTRL 8'h00
`define FD_REG_STATUS 8'h04
`define FD_REG_SRC 8'h08
`define FD_REG_COORD 8'h0c
`define FD_REG_WIN_XY 8'h10
`define FD_REG_WIN_WH 8'h14
`define FD_REG_SRC_W 8'h18
`define FD_REG_CLKDIV 8'h1c

// Control register fields.
`define FD_CTRL_SEL_LSB 0
`define FD_CTRL_COORD_SRC 4
`define FD_CTRL_ADDR32 5
`define FD_CTRL_BPP_LSB 6
`define FD_CTRL_BLOCK 8
`define FD_CTRL_START 9

// Status register fields.
`define FD_STAT_BUSY 0
`define FD_STAT_DONE 1

// Read selection codes.
`define FD_SEL_NORMAL 4'h0
`define FD_SEL_FAST 4'h4
`define FD_SEL_FASTEST 4'h8
`define FD_SEL_DUAL_OUT 4'h2
`define FD_SEL_DUAL_IO 4'h3
`define FD_SEL_QUAD_OUT 4'h7
`define FD_SEL_QIO_D4 4'h9
`define FD_SEL_QIO_D6 4'ha
`define FD_SEL_QPI_D6 4'hb
`define FD_SEL_QPI_D8 4'he

// Reset values and timing counts.
`define FD_DIV_RST 8'h02
`define FD_DIV_MIN 8'h02
`define FD_ADDR_BITS_24 6'h18
`define FD_ADDR_BITS_32 6'h20
`define FD_OPCODE_BITS 6'h08

`endif

// *** src/flash_dma_pkg.sv ***
package flash_dma_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_END
  } seq_state_t;

  // Lane counts are kept as log2: 0 one line, 1 two lines, 2 four lines.
  typedef struct packed {
    logic [7:0] opcode;
    logic [1:0] cmd_lg;
    logic [1:0] addr_lg;
    logic [1:0] data_lg;
    logic [4:0] dummy;
  } read_mode_t;

  typedef struct packed {
    logic valid;
    logic linear;
    logic [15:0] x;
    logic [15:0] y;
    logic [31:0] data;
  } mem_wr_t;

  typedef struct packed {
    logic [1:0] idx;
    logic [31:0] acc;
    logic pix_valid;
    logic [31:0] pix;
  } packer_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } div_state_t;

endpackage : flash_dma_pkg

// *** src/serial_tick_div.sv ***
`include "flash_dma_consts.svh"

// Half-period enable for the serial clock; the divisor is clamped so that
// a half period is never shorter than the input synchroniser delay.
module serial_tick_div #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic run_i,
  input wire logic [W-1:0] div_i,
  output logic tick_o
);
  flash_dma_pkg::div_state_t s, next_s;
  logic [W-1:0] lim;

  always_comb begin
    lim = (div_i < W'(`FD_DIV_MIN)) ? W'(`FD_DIV_MIN) : div_i;
    next_s = s;
    next_s.tick = 1'b0;
    if (!run_i) begin
      next_s.cnt = 8'h00;
    end else if (s.cnt >= 8'(lim)) begin
      next_s.cnt = 8'h00;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_o = s.tick;
endmodule : serial_tick_div

// *** src/pixel_packer.sv ***
`include "flash_dma_consts.svh"

// Gathers flash bytes into one pixel word, first byte in the low lane.
// No colour conversion is done; the word keeps the display memory layout.
module pixel_packer (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic clear_i,
  input wire logic [1:0] bpp_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  output logic pix_valid_o,
  output logic [31:0] pix_o
);
  flash_dma_pkg::packer_state_t s, next_s;
  logic [31:0] merged;

  always_comb begin
    next_s = s;
    next_s.pix_valid = 1'b0;
    merged = s.acc;
    merged[{s.idx, 3'b000} +: 8] = byte_i;
    if (clear_i) begin
      next_s.idx = 2'b00;
      next_s.acc = 32'h0000_0000;
    end else if (byte_valid_i) begin
      if (s.idx == bpp_i) begin
        next_s.pix_valid = 1'b1;
        next_s.pix = merged;
        next_s.idx = 2'b00;
        next_s.acc = 32'h0000_0000;
      end else begin
        next_s.acc = merged;
        next_s.idx = s.idx + 2'b01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pix_valid_o = s.pix_valid;
  assign pix_o = s.pix;
endmodule : pixel_packer

// *** src/serial_flash_read_dma.sv ***
// Decided for this implementation: the AHB-Lite register port and the address map.
`include "flash_dma_consts.svh"

// Functional notes
// - 1001b: quad I/O, one-line opcode, 4 dummies.
// - 1010b: same quad I/O read, 6 dummies.
// - 1011b: all-four-line opcode EBh, 6 dummies.
// - 1110b: all-four-line opcode EBh, 8 dummies.
// - Opcode follows 24-bit or 32-bit addressing; 1000b keeps 1Bh and the all-four-line modes keep EBh for both widths.
// - Address width bit picks 24 or 32 address bits.
// - Dual I/O address takes 12 or 16 clocks.
// - Dual output data: two bits per clock.
// - 8bpp: one byte per pixel, 3:3:2.
// - 16bpp: two bytes, low byte first.
// - 24bpp: three bytes, blue green red.
// - 32bpp: four bytes, blue green red alpha.
// - Source is flash; destination is active window.
// - Autonomous transfer, completion pulse to host.
// - Block mode fills rectangle pixel by pixel.
// - Coordinate bit: destination or source corner.
// - 0000b no dummies; 0100b eight dummies.
// - 0010b dual output 8; 0011b dual I/O 4.
module serial_flash_read_dma (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic flash_sclk_o,
  output logic flash_cs_n_o,
  output logic [3:0] flash_io_o,
  output logic [3:0] flash_io_oe_n_o,
  input wire logic [3:0] flash_io_i,
  output flash_dma_pkg::mem_wr_t mem_wr_o,
  output logic done_o
);
  typedef struct packed {
    flash_dma_pkg::seq_state_t st;
    logic [7:0] div;
    logic [3:0] sel;
    logic coord_src;
    logic addr32;
    logic [1:0] bpp;
    logic block;
    logic done;
    logic [31:0] src;
    logic [31:0] coord;
    logic [31:0] win_xy;
    logic [31:0] win_wh;
    logic [15:0] src_w;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    flash_dma_pkg::read_mode_t mode;
    logic sclk;
    logic cs_n;
    logic [31:0] sr;
    logic [31:0] faddr;
    logic [5:0] cnt;
    logic [7:0] rx;
    logic [3:0] rxn;
    logic [31:0] left;
    logic byte_v;
    logic [7:0] byte_d;
    logic [15:0] x0;
    logic [15:0] x;
    logic [15:0] y;
    flash_dma_pkg::mem_wr_t mem;
    logic irq;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] io;
    logic [3:0] oe_n;
  } dma_state_t;

  dma_state_t s, next_s;
  logic tick;
  logic pix_valid;
  logic [31:0] pix;
  logic start;
  logic [1:0] eff_bpp;
  logic [2:0] bpb;
  logic [31:0] npx;
  logic [31:0] off;
  logic [1:0] lg;
  logic [3:0] in_bits;
  logic [7:0] rx_new;

  function automatic flash_dma_pkg::read_mode_t decode(
    input logic [3:0] sel, input logic a32);
    flash_dma_pkg::read_mode_t m;
    m = '{opcode: a32 ? 8'h13 : 8'h03, cmd_lg: 2'd0, addr_lg: 2'd0,
          data_lg: 2'd0, dummy: 5'd0};
    case (sel)
      `FD_SEL_FAST: begin
        m.opcode = a32 ? 8'h0c : 8'h0b;
        m.dummy = 5'd8;
      end
      `FD_SEL_FASTEST: begin
        m.opcode = 8'h1b;
        m.dummy = 5'd16;
      end
      `FD_SEL_DUAL_OUT: begin
        m.opcode = a32 ? 8'h3c : 8'h3b;
        m.data_lg = 2'd1;
        m.dummy = 5'd8;
      end
      `FD_SEL_DUAL_IO: begin
        m.opcode = a32 ? 8'hbc : 8'hbb;
        m.addr_lg = 2'd1;
        m.data_lg = 2'd1;
        m.dummy = 5'd4;
      end
      `FD_SEL_QUAD_OUT: begin
        m.opcode = a32 ? 8'h6c : 8'h6b;
        m.data_lg = 2'd2;
        m.dummy = 5'd8;
      end
      // Quad I/O, opcode by address width.
      `FD_SEL_QIO_D4: begin
        m.opcode = a32 ? 8'hec : 8'heb;
        m.addr_lg = 2'd2;
        m.data_lg = 2'd2;
        m.dummy = 5'd4;
      end
      `FD_SEL_QIO_D6: begin
        m.opcode = a32 ? 8'hec : 8'heb;
        m.addr_lg = 2'd2;
        m.data_lg = 2'd2;
        m.dummy = 5'd6;
      end
      // Opcode on four lines, six dummies.
      `FD_SEL_QPI_D6: begin
        m = '{opcode: 8'heb, cmd_lg: 2'd2, addr_lg: 2'd2,
              data_lg: 2'd2, dummy: 5'd6};
      end
      // Opcode on four lines, eight dummies.
      `FD_SEL_QPI_D8: begin
        m = '{opcode: 8'heb, cmd_lg: 2'd2, addr_lg: 2'd2,
              data_lg: 2'd2, dummy: 5'd8};
      end
      default: begin
      end
    endcase
    return m;
  endfunction : decode

  serial_tick_div #(.W(8)) u_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .run_i(s.st != flash_dma_pkg::ST_IDLE),
    .div_i(s.div),
    .tick_o(tick)
  );

  pixel_packer u_pack (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .clear_i(start),
    .bpp_i(eff_bpp),
    .byte_valid_i(s.byte_v),
    .byte_i(s.byte_d),
    .pix_valid_o(pix_valid),
    .pix_o(pix)
  );

  always_comb begin
    next_s = s;
    next_s.byte_v = 1'b0;
    next_s.irq = 1'b0;
    next_s.mem.valid = 1'b0;
    next_s.sync1 = flash_io_i;
    next_s.sync2 = s.sync1;
    start = 1'b0;
    npx = 32'h0000_0000;
    off = 32'h0000_0000;
    lg = 2'd0;
    in_bits = 4'h0;
    rx_new = 8'h00;

    // Register writes land in the data phase.
    if (s.wr_pend) begin
      case (s.wr_addr)
        `FD_REG_CTRL: begin
          next_s.sel = hwdata_i[`FD_CTRL_SEL_LSB +: 4];
          next_s.coord_src = hwdata_i[`FD_CTRL_COORD_SRC];
          next_s.addr32 = hwdata_i[`FD_CTRL_ADDR32];
          next_s.bpp = hwdata_i[`FD_CTRL_BPP_LSB +: 2];
          next_s.block = hwdata_i[`FD_CTRL_BLOCK];
          start = hwdata_i[`FD_CTRL_START] &&
                  (s.st == flash_dma_pkg::ST_IDLE);
        end
        `FD_REG_SRC: next_s.src = hwdata_i;
        `FD_REG_COORD: next_s.coord = hwdata_i;
        `FD_REG_WIN_XY: next_s.win_xy = hwdata_i;
        `FD_REG_WIN_WH: next_s.win_wh = hwdata_i;
        `FD_REG_SRC_W: next_s.src_w = hwdata_i[15:0];
        `FD_REG_CLKDIV: next_s.div = hwdata_i[7:0];
        default: begin
        end
      endcase
    end

    // Linear mode moves plain bytes, one per memory item.
    eff_bpp = next_s.block ? next_s.bpp : 2'd0;
    bpb = 3'(eff_bpp) + 3'd1;

    case (s.st)
      flash_dma_pkg::ST_IDLE: begin
        next_s.sclk = 1'b0;
        next_s.cs_n = 1'b1;
        if (start) begin
          npx = 32'(next_s.win_wh[15:0] * next_s.win_wh[31:16]);
          // Coordinates name the source or destination corner.
          off = 32'(next_s.coord[31:16] * next_s.src_w) +
                32'(next_s.coord[15:0]);
          next_s.done = 1'b0;
          next_s.mode = decode(next_s.sel, next_s.addr32);
          // Destination starts at the window corner when coord_src is set, else at the coordinates.
          next_s.x0 = next_s.coord_src ? next_s.win_xy[15:0] :
                      next_s.coord[15:0];
          next_s.x = next_s.x0;
          next_s.y = next_s.coord_src ? next_s.win_xy[31:16] :
                     next_s.coord[31:16];
          next_s.faddr = next_s.coord_src ?
                         next_s.src + 32'(off * 32'(bpb)) : next_s.src;
          next_s.left = 32'(npx * 32'(bpb));
          next_s.rx = 8'h00;
          next_s.rxn = 4'h0;
          if (next_s.left != 32'h0000_0000) begin
            next_s.st = flash_dma_pkg::ST_CMD;
            next_s.cs_n = 1'b0;
            next_s.sr = {next_s.mode.opcode, 24'h000000};
            next_s.cnt = `FD_OPCODE_BITS >> next_s.mode.cmd_lg;
          end else begin
            next_s.done = 1'b1;
            next_s.irq = 1'b1;
          end
        end
      end
      flash_dma_pkg::ST_END: begin
        if (tick) begin
          if (s.sclk) begin
            next_s.sclk = 1'b0;
          end else begin
            next_s.cs_n = 1'b1;
            next_s.st = flash_dma_pkg::ST_IDLE;
            next_s.done = 1'b1;
            next_s.irq = 1'b1;
          end
        end
      end
      default: begin
        if (tick && !s.sclk) begin
          next_s.sclk = 1'b1;
          if (s.st == flash_dma_pkg::ST_DATA) begin
            // Data bits arrive on every returned line.
            case (s.mode.data_lg)
              2'd0: rx_new = {s.rx[6:0], s.sync2[1]};
              2'd1: rx_new = {s.rx[5:0], s.sync2[1:0]};
              default: rx_new = {s.rx[3:0], s.sync2};
            endcase
            in_bits = s.rxn + (4'h1 << s.mode.data_lg);
            next_s.rx = rx_new;
            next_s.rxn = in_bits;
            if (in_bits == 4'h8) begin
              next_s.rxn = 4'h0;
              next_s.byte_v = 1'b1;
              next_s.byte_d = rx_new;
              next_s.left = s.left - 32'h0000_0001;
              if (s.left == 32'h0000_0001) begin
                next_s.st = flash_dma_pkg::ST_END;
              end
            end
          end
        end else if (tick && s.sclk) begin
          next_s.sclk = 1'b0;
          lg = (s.st == flash_dma_pkg::ST_CMD) ? s.mode.cmd_lg :
               s.mode.addr_lg;
          next_s.cnt = s.cnt - 6'h01;
          next_s.sr = s.sr << (6'h01 << lg);
          if (s.cnt == 6'h01) begin
            case (s.st)
              flash_dma_pkg::ST_CMD: begin
                // Address clocks by width and lanes.
                next_s.st = flash_dma_pkg::ST_ADDR;
                next_s.sr = s.addr32 ? s.faddr : {s.faddr[23:0], 8'h00};
                next_s.cnt = (s.addr32 ? `FD_ADDR_BITS_32 :
                              `FD_ADDR_BITS_24) >> s.mode.addr_lg;
              end
              flash_dma_pkg::ST_ADDR: begin
                next_s.cnt = 6'(s.mode.dummy);
                next_s.st = (s.mode.dummy == 5'd0) ?
                            flash_dma_pkg::ST_DATA :
                            flash_dma_pkg::ST_DUMMY;
              end
              flash_dma_pkg::ST_DUMMY: next_s.st = flash_dma_pkg::ST_DATA;
              default: next_s.cnt = s.cnt;
            endcase
          end
        end
      end
    endcase

    // Block fill walks the window row by row.
    if (pix_valid) begin
      next_s.mem = '{valid: 1'b1, linear: !s.block, x: s.x, y: s.y,
                     data: pix};
      if (s.x == s.x0 + s.win_wh[15:0] - 16'h0001) begin
        next_s.x = s.x0;
        next_s.y = s.y + 16'h0001;
      end else begin
        next_s.x = s.x + 16'h0001;
      end
    end

    // Pin drive follows the phase being entered.
    next_s.io = 4'h0;
    next_s.oe_n = 4'hf;
    if (next_s.st != flash_dma_pkg::ST_IDLE) begin
      if (next_s.mode.data_lg != 2'd2) begin
        // Write-protect and hold stay inactive outside quad modes.
        next_s.io[3:2] = 2'b11;
        next_s.oe_n[3:2] = 2'b00;
      end
      case (next_s.st)
        flash_dma_pkg::ST_CMD, flash_dma_pkg::ST_ADDR: begin
          lg = (next_s.st == flash_dma_pkg::ST_CMD) ?
               next_s.mode.cmd_lg : next_s.mode.addr_lg;
          case (lg)
            2'd0: begin
              next_s.io[0] = next_s.sr[31];
              next_s.oe_n[0] = 1'b0;
            end
            2'd1: begin
              next_s.io[1:0] = next_s.sr[31:30];
              next_s.oe_n[1:0] = 2'b00;
            end
            default: begin
              next_s.io = next_s.sr[31:28];
              next_s.oe_n = 4'h0;
            end
          endcase
        end
        default: begin
          if (next_s.mode.data_lg == 2'd0) begin
            next_s.oe_n[0] = 1'b0;
          end
        end
      endcase
    end

    // Reads see any write of the previous data phase.
    next_s.wr_pend = 1'b0;
    if (hsel_i && htrans_i[1] && hready_i) begin
      next_s.wr_pend = hwrite_i;
      next_s.wr_addr = haddr_i[7:0];
      case (haddr_i[7:0])
        `FD_REG_CTRL: next_s.hrdata = {23'h0, next_s.block, next_s.bpp,
          next_s.addr32, next_s.coord_src, next_s.sel};
        `FD_REG_STATUS: next_s.hrdata = {30'h0, next_s.done,
          next_s.st != flash_dma_pkg::ST_IDLE};
        `FD_REG_SRC: next_s.hrdata = next_s.src;
        `FD_REG_COORD: next_s.hrdata = next_s.coord;
        `FD_REG_WIN_XY: next_s.hrdata = next_s.win_xy;
        `FD_REG_WIN_WH: next_s.hrdata = next_s.win_wh;
        `FD_REG_SRC_W: next_s.hrdata = {16'h0, next_s.src_w};
        `FD_REG_CLKDIV: next_s.hrdata = {24'h0, next_s.div};
        default: next_s.hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s <= '0;
      s.st <= flash_dma_pkg::ST_IDLE;
      s.div <= `FD_DIV_RST;
      s.cs_n <= 1'b1;
      s.oe_n <= 4'hf;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata_o = s.hrdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign flash_sclk_o = s.sclk;
  assign flash_cs_n_o = s.cs_n;
  assign flash_io_o = s.io;
  assign flash_io_oe_n_o = s.oe_n;
  assign mem_wr_o = s.mem;
  assign done_o = s.irq;
endmodule : serial_flash_read_dma

// *** tb/flash_dma_props.sv ***
module flash_dma_props (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic flash_sclk_o,
  input wire logic flash_cs_n_o,
  input wire logic [3:0] flash_io_o,
  input wire logic [3:0] flash_io_oe_n_o,
  input wire logic [3:0] flash_io_i,
  input wire flash_dma_pkg::mem_wr_t mem_wr_o,
  input wire logic done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  // The divisor is clamped, so a half period never lasts under 3 clocks.
  sequence high_half;
    flash_sclk_o [*2];
  endsequence
  sequence low_half;
    !flash_sclk_o [*2];
  endsequence
  a_bus_okay:
    assert property (hreadyout_o && !hresp_o) else $error("bus not okay");
  a_reset_idle:
    assert property (disable iff (1'b0) !rstn_i |=> flash_cs_n_o && !done_o
      && flash_io_oe_n_o == 4'hf) else $error("reset state wrong");
  a_done_single:
    assert property (done_o |=> !done_o) else $error("done too long");
  a_done_cs_high:
    assert property (done_o |-> flash_cs_n_o) else $error("done in frame");
  a_cs_rise_done:
    assert property ($rose(flash_cs_n_o) |-> ##[0:2] done_o)
      else $error("frame ended without done");
  a_sclk_idle_low:
    assert property (flash_cs_n_o |-> !flash_sclk_o) else $error("sclk idle");
  a_sclk_high_min:
    assert property ($rose(flash_sclk_o) |=> high_half)
      else $error("sclk high too short");
  a_sclk_low_min:
    assert property ($fell(flash_sclk_o) |=> low_half)
      else $error("sclk low too short");
  a_io_change_low:
    assert property ($changed(flash_io_o) |-> !flash_sclk_o)
      else $error("data line changed with sclk high");
  a_mem_single:
    assert property (mem_wr_o.valid |=> !mem_wr_o.valid)
      else $error("memory write too long");
endmodule : flash_dma_props

bind serial_flash_read_dma flash_dma_props props_u (
  .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .flash_sclk_o(flash_sclk_o),
  .flash_cs_n_o(flash_cs_n_o), .flash_io_o(flash_io_o),
  .flash_io_oe_n_o(flash_io_oe_n_o), .flash_io_i(flash_io_i),
  .mem_wr_o(mem_wr_o), .done_o(done_o)
);

// *** tb/flash_model.sv ***
module flash_model (
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  input wire logic [5:0] lg_i,
  input wire logic [4:0] dummy_i,
  input wire logic a32_i,
  output logic [3:0] io_o,
  output logic [7:0] op_o,
  output logic [31:0] addr_o,
  output int frames_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int k, dbit, oc, ac, n;
  logic [7:0] b;
  function automatic logic [7:0] fbyte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : fbyte
  function automatic logic [3:0] take(input logic [1:0] lg,
                                      input logic [3:0] v);
    return v & 4'((1 << (1 << lg)) - 1);
  endfunction : take
  initial begin
    io_o = 4'h5;
    frames_o = 0;
  end
  always @(negedge cs_n_i) begin
    k = 0;
    dbit = 0;
    op_o = 8'h00;
    addr_o = 32'h0;
    frames_o++;
    oc = 8 >> lg_i[5:4];
    ac = (a32_i ? 32 : 24) >> lg_i[3:2];
  end
  always @(posedge sclk_i) begin
    if (!cs_n_i && k < oc)
      op_o = (op_o << (1 << lg_i[5:4])) | 8'(take(lg_i[5:4], io_i));
    else if (!cs_n_i && k < oc + ac)
      addr_o = (addr_o << (1 << lg_i[3:2])) | 32'(take(lg_i[3:2], io_i));
    k++;
  end
  // Data out MSB first.
  // Lines not carrying data toggle, so a stale sample never looks valid.
  always @(negedge sclk_i or posedge cs_n_i) begin
    io_o = ~io_o;
    if (!cs_n_i && k >= oc + ac + int'(dummy_i)) begin
      n = 1 << lg_i[1:0];
      b = fbyte(addr_o + 32'(dbit / 8)) << (dbit % 8);
      if (n == 1) io_o[1] = b[7];
      else if (n == 2) io_o[1:0] = b[7:6];
      else io_o = b[7:4];
      dbit += n;
    end
  end
endmodule : flash_model

// *** tb/serial_flash_read_dma_tb.sv ***
`include "flash_dma_consts.svh"

module serial_flash_read_dma_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rstn_i, hsel, hwrite, hready, hresp, sclk, cs_n, done, a32;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [3:0] io_o, oe_n, mdl_io, io_in;
  logic [5:0] lg;
  logic [4:0] dum;
  flash_dma_pkg::mem_wr_t mem_wr;
  flash_dma_pkg::mem_wr_t wr_q[$];
  int fails, tests_run, seed;
  logic [3:0] sels[10] = '{4'h0, 4'h4, 4'h8, 4'h2, 4'h3, 4'h7, 4'h9, 4'ha,
                            4'hb, 4'he};
  logic [15:0] ops[10] = '{16'h0313, 16'h0b0c, 16'h1b1b, 16'h3b3c, 16'hbbbc,
                           16'h6b6c, 16'hebec, 16'hebec, 16'hebeb, 16'hebeb};
  logic [4:0] dums[10] = '{5'h00, 5'h08, 5'h10, 5'h08, 5'h04, 5'h08, 5'h04,
                           5'h06, 5'h06, 5'h08};
  logic [5:0] lgs[10] = '{6'h00, 6'h00, 6'h00, 6'h01, 6'h05, 6'h02, 6'h0a,
                          6'h0a, 6'h2a, 6'h2a};
  assign io_in = (oe_n & mdl_io) | (~oe_n & io_o);
  serial_flash_read_dma dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .flash_sclk_o(sclk), .flash_cs_n_o(cs_n),
    .flash_io_o(io_o), .flash_io_oe_n_o(oe_n), .flash_io_i(io_in),
    .mem_wr_o(mem_wr), .done_o(done)
  );
  flash_model fm_u (
    .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_in), .lg_i(lg), .dummy_i(dum),
    .a32_i(a32), .io_o(mdl_io), .op_o(), .addr_o(), .frames_o()
  );
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (mem_wr.valid === 1'b1) wr_q.push_back(mem_wr);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // Entered just after a rising edge; returns just after the data phase.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    rd = hrdata;
  endtask : ahb
  task automatic run(input int m, input logic [31:0] r, input logic src,
                     input logic blk, input logic twice);
    logic [31:0] fa, ctrl;
    logic [15:0] w, h, dx, dy, cx, cy, wx, wy;
    logic [1:0] bpp;
    int nb, f0, n;
    logic [31:0] e;
    bpp = blk ? r[2:1] : 2'h0;
    nb = int'(bpp) + 1;
    w = 16'(r[3]) + 16'h1;
    h = 16'(r[4]) + 16'h1;
    cx = 16'(r[7:5]);
    cy = 16'(r[10:8]);
    wx = 16'(r[13:11]);
    wy = 16'(r[16:14]);
    dx = src ? wx : cx;
    dy = src ? wy : cy;
    a32 = r[0];
    lg = lgs[m];
    dum = dums[m];
    fa = src ? r + 32'((cy * 16'h8 + cx) * nb) : r;
    if (!a32) fa[31:24] = 8'h00;
    ctrl = {22'h0, 1'b1, blk, bpp, a32, src, sels[m]};
    f0 = fm_u.frames_o;
    wr_q.delete();
    ahb(1'b1, `FD_REG_SRC, r);
    ahb(1'b1, `FD_REG_COORD, {cy, cx});
    ahb(1'b1, `FD_REG_WIN_XY, {wy, wx});
    ahb(1'b1, `FD_REG_WIN_WH, {h, w});
    ahb(1'b1, `FD_REG_SRC_W, 32'h8);
    ahb(1'b1, `FD_REG_CTRL, ctrl);
    if (twice) begin
      repeat (40) @(posedge clk_i);
      ahb(1'b1, `FD_REG_CTRL, ctrl);
    end
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    check(32'(n < 20000), 32'h1);
    ahb(1'b0, `FD_REG_STATUS, 32'h0);
    check(rd, 32'h2);
    check(32'(fm_u.frames_o - f0), 32'h1);
    check(32'(fm_u.op_o), 32'(a32 ? ops[m][7:0] : ops[m][15:8]));
    check(fm_u.addr_o, fa);
    check(32'(wr_q.size()), 32'(w * h));
    for (int i = 0; i < wr_q.size(); i++) begin
      e = 32'h0;
      for (int j = 0; j < nb; j++) e[8*j +: 8] = fm_u.fbyte(fa + 32'(i*nb + j));
      check(wr_q[i].data, e);
      check({wr_q[i].y, wr_q[i].x},
            {dy + 16'(i) / w, dx + 16'(i) % w});
      check(32'(wr_q[i].linear), 32'(!blk));
    end
    $display("test mode %0d done", m);
  endtask : run
  initial begin
    repeat (3000) @(posedge clk_i);
    repeat (57000) @(posedge clk_i);
    fails++;
    $display("unexpected at %0t: got %h expected %h", $time, 0, 1);
    end_of_test();
  end
  initial begin
    seed = 8;
    fails = 0;
    tests_run = 0;
    {hsel, hwrite, htrans, haddr, hwdata, a32, lg, dum} = '0;
    hsize = 3'h2;
    rstn_i = 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    ahb(1'b0, `FD_REG_CLKDIV, 32'h0);
    check(rd, 32'h2);
    ahb(1'b0, `FD_REG_STATUS, 32'h0);
    check(rd, 32'h0);
    ahb(1'b1, 8'h20, 32'hffffffff);
    ahb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    // A divisor of 3 gives the 160 ns serial clock.
    ahb(1'b1, `FD_REG_CLKDIV, 32'h3);
    ahb(1'b0, `FD_REG_CLKDIV, 32'h0);
    check(rd, 32'h3);
    $display("test registers done");
    for (int i = 0; i < 10; i++) run(i, 32'($random(seed)), 1'b0, 1'b1, 1'b0);
    run(4, 32'($random(seed)), 1'b1, 1'b1, 1'b0);
    run(0, 32'($random(seed)), 1'b0, 1'b0, 1'b0);
    run(9, 32'($random(seed)), 1'b0, 1'b1, 1'b1);
    end_of_test();
  end
endmodule : serial_flash_read_dma_tb
